/* rtl/sli_pkg.sv */
// Constants, register map and types for the status light controller.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
//
// What this block does
// - Several active conditions show only the highest-priority condition's pattern.
// - Error or warning display also raises a status message code.
// - Light is dark only on hardware fault; every working state lights it.
// - Fatal error blinks red at 1 Hz; backup firmware load blinks red 4 Hz.
// - Out-of-range operating condition holds red steady as a warning.
// - Awaiting or receiving a download blinks blue at 1 Hz.
// - Writing flash blinks blue at 4 Hz, warning not to cut power.
// - Initialisation or a long command blinks green at 1 Hz.
// - Each received serial command gives at least one green flash, except while the light is dark on hardware fault.
// - Normal operation with nothing else active holds green steady.
// - After power-up, blink during about ten seconds of init, then green.
package sli_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int SLOW_HZ = 1;
    localparam int FAST_HZ = 4;
    localparam int INIT_S = 10;
    // Half period in cycles: toggle point of a 50 percent blink
    localparam logic [31:0] SLOW_HALF = 32'(CLK_HZ / (2 * SLOW_HZ));
    localparam logic [31:0] FAST_HALF = 32'(CLK_HZ / (2 * FAST_HZ));
    localparam longint INIT_CYC_L = longint'(CLK_HZ) * INIT_S;
    localparam logic [31:0] INIT_CYC = INIT_CYC_L[31:0];
    // One green acknowledge flash lasts one fast half period
    localparam logic [31:0] ACK_CYC = FAST_HALF;

    // ------------------------------------------------------------
    // Register map (byte addresses, word index = addr[5:2])
    // ------------------------------------------------------------
    localparam logic [3:0] REG_COND = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_SLOW_DIV = 4'h4;
    localparam logic [3:0] REG_FAST_DIV = 4'h5;
    localparam logic [3:0] REG_CMD = 4'h6;
    localparam logic [31:0] BAD_ADDR_DATA = 32'hdead_0bad;

    // Condition bits in REG_COND
    localparam int C_FATAL = 0;
    localparam int C_BACKUP = 1;
    localparam int C_FLASH = 2;
    localparam int C_DOWNLOAD = 3;
    localparam int C_WARN = 4;
    localparam int C_LONGCMD = 5;
    localparam int C_HWFAULT = 6;
    localparam int NCOND = 7;

    // Interrupt bits
    localparam int I_MSG = 0;
    localparam int I_CMD = 1;
    localparam int I_INIT_DONE = 2;
    localparam int NIRQ = 3;

    // Reset values
    localparam logic [NCOND-1:0] COND_RST = 7'h00;
    localparam logic [NIRQ-1:0] MASK_RST = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SLI_OFF, SLI_RED, SLI_BLUE, SLI_GREEN} sli_colour_t;
    typedef enum logic [1:0] {SLI_STEADY, SLI_SLOW, SLI_FAST} sli_blink_t;
    typedef enum logic [3:0] {
        SEL_DARK, SEL_FATAL, SEL_BACKUP, SEL_FLASH, SEL_DOWNLOAD,
        SEL_WARN, SEL_INIT, SEL_OPER
    } sli_sel_t;

endpackage

/* rtl/sli_blink_if.sv */
// Blink request and result between the controller and its divider.
// Assumes both ends share the controller's clock.
`timescale 1ns/100ps
interface sli_blink_if;
    import sli_pkg::*;
    logic [31:0] half_cyc;
    logic restart;
    logic phase;

    // ------------------------------------------------------------
    // Roles
    // ------------------------------------------------------------
    modport ctrl (output half_cyc, output restart, input phase);
    modport gen (input half_cyc, input restart, output phase);
endinterface

/* rtl/sli_blinker.sv */
// Programmable half-period blink divider with phase restart.
// Assumes half_cyc is at least one.
`timescale 1ns/100ps
module sli_blinker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Blink control
    sli_blink_if.gen bl
);
    import sli_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic phase;
    } sli_bk_t;

    sli_bk_t st, next_st;

    // Count half periods and toggle; a restart starts lit
    always_comb begin
        next_st = st;
        if (bl.restart) begin
            next_st.cnt = 32'h0;
            next_st.phase = 1'b1;
        end else if (st.cnt + 32'h1 >= bl.half_cyc) begin
            next_st.cnt = 32'h0;
            next_st.phase = ~st.phase;
        end else begin
            next_st.cnt = st.cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{cnt: 32'h0, phase: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign bl.phase = st.phase;
endmodule

/* rtl/sli_top.sv */
// Status light controller: condition priority, blink and register slave.
// Assumes a standard Avalon-MM master with waitrequest and a lamp driven high = lit.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module sli_top
    import sli_pkg::*;
#(
    parameter logic [31:0] INIT_CYCLES = sli_pkg::INIT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial command received strobe
    input wire logic cmd_rx,
    // Light drive
    output logic led_red,
    output logic led_green,
    output logic led_blue,
    // Status message and interrupt
    output logic msg_valid,
    output logic [3:0] msg_code,
    output logic irq
);
    import sli_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Whole block state; one copy is built each cycle and registered
    typedef struct packed {
        logic [NCOND-1:0] cond;
        logic [31:0] slow_half;
        logic [31:0] fast_half;
        logic [NIRQ-1:0] istat;
        logic [NIRQ-1:0] imask;
        logic [31:0] init_cnt;
        logic init_done;
        logic [31:0] ack_cnt;
        logic ack_on;
        logic [3:0] sel;
        logic [3:0] shown;
        logic restart;
        logic [31:0] rdata;
        logic stall;
        logic red;
        logic green;
        logic blue;
        logic mvalid;
        logic [3:0] mcode;
        logic irq;
        logic [7:0] cmd_count;
    } sli_state_t;

    sli_state_t st, next_st;

    // One divider per rate; both see the same restart pulse
    sli_blink_if slow_bl();
    sli_blink_if fast_bl();

    // ------------------------------------------------------------
    // Blink dividers
    // ------------------------------------------------------------
    sli_blinker u_slow (
        .clk(clk),
        .rst(rst),
        .bl(slow_bl.gen)
    );
    sli_blinker u_fast (
        .clk(clk),
        .rst(rst),
        .bl(fast_bl.gen)
    );

    // Software-programmed half periods feed the dividers
    assign slow_bl.half_cyc = st.slow_half;
    assign fast_bl.half_cyc = st.fast_half;
    assign slow_bl.restart = st.restart;
    assign fast_bl.restart = st.restart;

    // Byte-lane merge of a 32-bit write
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Terminal count shared by the timers; testing cnt + 1 lets a limit
    // of one expire after a single cycle
    function automatic logic reached(input logic [31:0] cnt, input logic [31:0] lim);
        return (cnt + 32'h1) >= lim;
    endfunction

    // Colour to lamp lines {red, green, blue}; dark when not lit
    function automatic logic [2:0] lamp_of(input sli_colour_t c, input logic on);
        logic [2:0] v;
        v = 3'h0;
        if (on) begin
            if (c == SLI_RED) begin
                v = 3'h4;
            end else if (c == SLI_GREEN) begin
                v = 3'h2;
            end else if (c == SLI_BLUE) begin
                v = 3'h1;
            end
        end
        return v;
    endfunction

    // Highest-priority active condition
    // Hardware fault outranks everything: a dead lamp is the only dark state
    function automatic sli_sel_t pick(input logic [NCOND-1:0] c, input logic idone);
        if (c[C_HWFAULT]) begin
            return SEL_DARK;
        end else if (c[C_FATAL]) begin
            return SEL_FATAL;
        end else if (c[C_BACKUP]) begin
            return SEL_BACKUP;
        end else if (c[C_FLASH]) begin
            return SEL_FLASH;
        end else if (c[C_DOWNLOAD]) begin
            return SEL_DOWNLOAD;
        end else if (c[C_WARN]) begin
            return SEL_WARN;
        end else if (c[C_LONGCMD] || !idone) begin
            return SEL_INIT;
        end else begin
            return SEL_OPER;
        end
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic req;
        logic acc;
        logic wr;
        logic [3:0] idx;
        logic [31:0] wv;
        logic [NIRQ-1:0] ev;
        logic lit;
        sli_colour_t col;
        sli_blink_t bk;
        // Taken on the edge where waitrequest stands low
        req = avs_read || avs_write;
        acc = req && !st.stall;
        wr = acc && avs_write;
        idx = avs_address[5:2];
        wv = 32'h0;
        ev = '0;
        lit = 1'b0;
        col = SLI_GREEN;
        bk = SLI_STEADY;
        next_st = st;
        next_st.restart = 1'b0;
        next_st.mvalid = 1'b0;

        // ------------------------------------------------------------
        // Bus slave
        // ------------------------------------------------------------
        // Stall drops for one cycle per request, so every access sees
        // exactly one wait state, back-to-back ones too
        next_st.stall = !(req && st.stall);

        // Register writes land on the accepting edge only
        if (wr) begin
            if (idx == REG_COND) begin
                wv = be_merge({25'h0, st.cond}, avs_writedata, avs_byteenable);
                next_st.cond = wv[NCOND-1:0];
            end else if (idx == REG_IRQ_MASK) begin
                next_st.imask = avs_writedata[NIRQ-1:0];
            end else if (idx == REG_SLOW_DIV) begin
                wv = be_merge(st.slow_half, avs_writedata, avs_byteenable);
                next_st.slow_half = (wv == 32'h0) ? 32'h1 : wv;
            end else if (idx == REG_FAST_DIV) begin
                wv = be_merge(st.fast_half, avs_writedata, avs_byteenable);
                next_st.fast_half = (wv == 32'h0) ? 32'h1 : wv;
            end
        end

        // Read data is loaded on the stalled edge, so it already stands
        // when waitrequest drops and the master samples it
        if (avs_read && st.stall) begin
            if (idx == REG_COND) begin
                next_st.rdata = {25'h0, st.cond};
            end else if (idx == REG_STATUS) begin
                next_st.rdata = {16'h0, st.cmd_count, st.shown, 3'h0, st.init_done};
            end else if (idx == REG_IRQ_STAT) begin
                next_st.rdata = {29'h0, st.istat};
            end else if (idx == REG_IRQ_MASK) begin
                next_st.rdata = {29'h0, st.imask};
            end else if (idx == REG_SLOW_DIV) begin
                next_st.rdata = st.slow_half;
            end else if (idx == REG_FAST_DIV) begin
                next_st.rdata = st.fast_half;
            end else if (idx == REG_CMD) begin
                next_st.rdata = {24'h0, st.cmd_count};
            end else begin
                next_st.rdata = BAD_ADDR_DATA;
            end
        end

        // ------------------------------------------------------------
        // Timers
        // ------------------------------------------------------------
        // Power-up initialisation window; runs once, no later restart
        if (!st.init_done) begin
            if (reached(st.init_cnt, INIT_CYCLES)) begin
                next_st.init_done = 1'b1;
                ev[I_INIT_DONE] = 1'b1;
            end else begin
                next_st.init_cnt = st.init_cnt + 32'h1;
            end
        end

        // Command acknowledge flash, retriggered by each command
        // A burst of commands keeps the lamp green rather than flickering
        if (cmd_rx) begin
            next_st.ack_on = 1'b1;
            next_st.ack_cnt = 32'h0;
            next_st.cmd_count = st.cmd_count + 8'h1;
            ev[I_CMD] = 1'b1;
        end else if (st.ack_on) begin
            if (reached(st.ack_cnt, ACK_CYC)) begin
                next_st.ack_on = 1'b0;
            end else begin
                next_st.ack_cnt = st.ack_cnt + 32'h1;
            end
        end

        // ------------------------------------------------------------
        // Selection and light
        // ------------------------------------------------------------
        // Priority select; change restarts both blink phases; the lamp shows a new
        // pattern for one cycle on the old phase, then opens a full lit half period
        next_st.sel = 4'(pick(st.cond, st.init_done));
        if (next_st.sel != st.sel) begin
            next_st.restart = 1'b1;
        end
        next_st.shown = st.sel;

        // Status message on entering an error or warning pattern
        // One pulse per entry; the code stays on msg_code for software
        if (next_st.sel != st.sel &&
            (next_st.sel == 4'(SEL_FATAL) || next_st.sel == 4'(SEL_BACKUP) ||
             next_st.sel == 4'(SEL_WARN))) begin
            next_st.mvalid = 1'b1;
            next_st.mcode = next_st.sel;
            ev[I_MSG] = 1'b1;
        end

        // Map selection to colour and blink; steady green unless listed
        case (sli_sel_t'(st.sel))
            SEL_DARK: begin
                col = SLI_OFF;
            end
            SEL_FATAL: begin
                col = SLI_RED;
                bk = SLI_SLOW;
            end
            SEL_BACKUP: begin
                col = SLI_RED;
                bk = SLI_FAST;
            end
            SEL_FLASH: begin
                col = SLI_BLUE;
                bk = SLI_FAST;
            end
            SEL_DOWNLOAD: begin
                col = SLI_BLUE;
                bk = SLI_SLOW;
            end
            SEL_WARN: begin
                col = SLI_RED;
            end
            SEL_INIT: begin
                col = SLI_GREEN;
                bk = SLI_SLOW;
            end
            default: begin
                col = SLI_GREEN;
            end
        endcase
        lit = (bk == SLI_STEADY) || (bk == SLI_SLOW && slow_bl.phase) ||
              (bk == SLI_FAST && fast_bl.phase);

        // Acknowledge flash overrides with green, but never on a dead light
        if (st.ack_on && col != SLI_OFF) begin
            {next_st.red, next_st.green, next_st.blue} = lamp_of(SLI_GREEN, 1'b1);
        end else begin
            {next_st.red, next_st.green, next_st.blue} = lamp_of(col, lit);
        end

        // ------------------------------------------------------------
        // Interrupts
        // ------------------------------------------------------------
        // Sticky interrupt status: set wins over write-one clear, so an
        // event in the clearing cycle is never lost
        if (wr && idx == REG_IRQ_STAT) begin
            next_st.istat = st.istat & ~avs_writedata[NIRQ-1:0];
        end
        next_st.istat = next_st.istat | ev;
        next_st.irq = |(next_st.istat & next_st.imask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.cond <= COND_RST;
            st.imask <= MASK_RST;
            st.slow_half <= SLOW_HALF;
            st.fast_half <= FAST_HALF;
            st.sel <= 4'(SEL_INIT);
            st.shown <= 4'(SEL_INIT);
            // Stalled while idle: the first request still sees its wait state
            st.stall <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.stall;
    assign led_red = st.red;
    assign led_green = st.green;
    assign led_blue = st.blue;
    assign msg_valid = st.mvalid;
    assign msg_code = st.mcode;
    assign irq = st.irq;
endmodule

/* tb/sli_chk.sv */
// Port checker for the status light controller.
// Assumes it is bound to sli_top: one clock, async active-high reset.
`timescale 1ns/100ps
module sli_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Command strobe and light
    input wire logic cmd_rx,
    input wire logic led_red,
    input wire logic led_green,
    input wire logic led_blue,
    // Status message
    input wire logic msg_valid,
    input wire logic [3:0] msg_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Bus handshake: one wait state, stall stands while idle
    // ------------------------------------------------------------
    property p_wait_rd;
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait_rd: assert property (p_wait_rd) else $error("read wait state wrong");
    property p_wait_wr;
        $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait_wr: assert property (p_wait_wr) else $error("write wait state wrong");
    property p_wait_idle;
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("no wait state ready after idle");

    // ------------------------------------------------------------
    // Light and message relations
    // ------------------------------------------------------------
    property p_one_colour;
        $onehot0({led_red, led_green, led_blue});
    endproperty
    a_one_colour: assert property (p_one_colour) else $error("two colours lit");
    property p_msg_code;
        msg_valid |-> (msg_code == 4'h1 || msg_code == 4'h2 || msg_code == 4'h5);
    endproperty
    a_msg_code: assert property (p_msg_code) else $error("message for non error state");
    property p_msg_pulse;
        msg_valid |=> !msg_valid;
    endproperty
    a_msg_pulse: assert property (p_msg_pulse) else $error("message longer than a pulse");
    property p_init_green;
        $fell(rst) |-> ##[0:4] led_green;
    endproperty
    a_init_green: assert property (p_init_green) else $error("no green at start");
    // Acknowledge overrides red and blue for a while
    property p_ack_no_red;
        cmd_rx |-> ##4 (!led_red && !led_blue) [*4];
    endproperty
    a_ack_no_red: assert property (p_ack_no_red) else $error("red or blue during ack");
    property p_ack_green;
        cmd_rx |-> ##[1:4] (led_green || !(led_red || led_blue));
    endproperty
    a_ack_green: assert property (p_ack_green) else $error("ack not green");
endmodule

bind sli_top sli_chk sli_chk_i (.clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .cmd_rx(cmd_rx), .led_red(led_red), .led_green(led_green),
    .led_blue(led_blue), .msg_valid(msg_valid), .msg_code(msg_code));

/* tb/sli_led_model.sv */
// Tri-colour lamp observer: counts lit cycles and changes per colour.
// Assumes the lamp is sampled on the controller clock, high = lit.
`timescale 1ns/100ps
module sli_led_model (
    // Clock and count clear
    input wire logic clk,
    input wire logic clr,
    // Lamp drive, index 0 red, 1 green, 2 blue
    input wire logic [2:0] led,
    // Counts since last clear
    output logic [2:0][7:0] n_lit,
    output logic [2:0][7:0] n_chg
);
    logic [2:0] prev;
    // Changes count rate, lit count duty; a dark lamp counts nothing
    always_ff @(posedge clk) begin
        prev <= led;
        for (int i = 0; i < 3; i++) begin
            n_lit[i] <= clr ? 8'h00 : n_lit[i] + 8'(led[i]);
            n_chg[i] <= clr ? 8'h00 : n_chg[i] + 8'(led[i] != prev[i]);
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the status light controller.
// Assumes short init (50 cycles) and dividers rewritten to 4 and 2.
`timescale 1ns/100ps
module testbench;
    import sli_pkg::*;
    logic clk, rst, avs_read, avs_write, cmd_rx, clr, avs_waitrequest;
    logic led_red, led_green, led_blue, msg_valid, irq;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable, msg_code;
    logic [2:0][7:0] n_lit, n_chg;
    int n_mismatch = 0;
    int samples_checked = 0;
    // Priority cascade: each step drops the top condition; the last sets hardware fault alone
    int t_cond [8] = '{'h3f, 'h3e, 'h3c, 'h38, 'h30, 'h20, 'h00, 'h40};
    int t_code [8] = '{1, 2, 3, 4, 5, 6, 7, 0};
    int t_col [8] = '{0, 0, 2, 2, 0, 1, 1, 3};
    int t_mode [8] = '{1, 2, 2, 1, 0, 1, 0, 0};

    sli_top #(.INIT_CYCLES(32'd50)) sli_top_i (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cmd_rx(cmd_rx), .led_red(led_red), .led_green(led_green), .led_blue(led_blue),
        .msg_valid(msg_valid), .msg_code(msg_code), .irq(irq));
    sli_led_model sli_led_model_i (.clk(clk), .clr(clr), .led({led_blue, led_green, led_red}),
        .n_lit(n_lit), .n_chg(n_chg));

    // ------------------------------------------------------------
    // Clock, compare, verdict
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus master: hold until waitrequest sampled low
    // ------------------------------------------------------------
    task automatic bus(input logic wr_n, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= !wr_n;
        avs_read <= wr_n;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (!avs_waitrequest) break;
        end
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 50) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b0, a, d, r);
    endtask
    // Let the lamp settle, then count 16 cycles
    task automatic look(input logic [23:0] lit, input logic [23:0] chg);
        repeat (8) @(posedge clk);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        repeat (17) @(posedge clk);
        check("lit_cycles", 32'(n_lit), 32'(lit));
        check("changes", 32'(n_chg), 32'(chg));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        bus(1'b1, 6'h04, 32'h0, q);
        check("init_busy", 32'(q[0]), 32'h0);
        check("init_lit", 32'(led_green), 32'h1);
        bus(1'b1, 6'h0c, 32'h0, q);
        check("mask_rst", q, 32'h0);
        bus(1'b1, 6'h10, 32'h0, q);
        check("slow_rst", q, 32'd50_000_000);
        bus(1'b1, 6'h14, 32'h0, q);
        check("fast_rst", q, 32'd12_500_000);
        bus(1'b1, 6'h1c, 32'h0, q);
        check("unmapped", q, 32'hdead_0bad);
        repeat (60) @(posedge clk);
        bus(1'b1, 6'h04, 32'h0, q);
        check("init_done", 32'(q[7:0]), 32'h71);
        bus(1'b1, 6'h08, 32'h0, q);
        check("init_irq", 32'(q[2]), 32'h1);
        wr(6'h08, 32'h7);
        wr(6'h0c, 32'h1);
        wr(6'h10, 32'h4);
        wr(6'h14, 32'h2);
        $display("test reset done");
    endtask
    task automatic t_prio();
        for (int i = 0; i < 8; i++) begin
            wr(6'h00, 32'(t_cond[i]));
            repeat (2) @(posedge clk);
            bus(1'b1, 6'h04, 32'h0, q);
            check("sel_code", 32'(q[7:4]), 32'(t_code[i]));
            look(24'(t_mode[i] == 0 ? 16 : 8) << (8 * t_col[i]), 24'(4 * t_mode[i]) << (8 * t_col[i]));
        end
        check("msg_code", 32'(msg_code), 32'h5);
        check("irq_set", 32'(irq), 32'h1);
        wr(6'h0c, 32'h0);
        repeat (3) @(posedge clk);
        check("irq_masked", 32'(irq), 32'h0);
        wr(6'h0c, 32'h1);
        repeat (3) @(posedge clk);
        check("irq_sticky", 32'(irq), 32'h1);
        wr(6'h08, 32'h1);
        repeat (3) @(posedge clk);
        check("irq_clear", 32'(irq), 32'h0);
        $display("test priority done");
    endtask
    task automatic t_cmd();
        wr(6'h00, 32'h10);
        @(posedge clk) cmd_rx <= 1'b1;
        @(posedge clk) cmd_rx <= 1'b0;
        look(24'h001000, 24'h0);
        bus(1'b1, 6'h04, 32'h0, q);
        check("cmd_count", 32'(q[15:8]), 32'h1);
        bus(1'b1, 6'h18, 32'h0, q);
        check("cmd_reg", q, 32'h1);
        bus(1'b1, 6'h08, 32'h0, q);
        check("cmd_irq", 32'(q[1]), 32'h1);
        wr(6'h00, 32'h40);
        look(24'h0, 24'h0);
        wr(6'h00, 32'h0);
        look(24'h001000, 24'h0);
        $display("test command done");
    endtask

    initial begin
        rst = 1'b1;
        avs_address = 6'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        avs_read = 1'b0;
        avs_write = 1'b0;
        cmd_rx = 1'b0;
        clr = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_prio();
        t_cmd();
        print_verdict();
    end
endmodule
